// ### bench/ivc_periph_model.sv
`timescale 1ns/1ps
module ivc_periph_model
    import ivc_pkg::*;
#(
    parameter logic [ADDR_W-1:0] CHAIN_VEC = 32'h0000_5000
)
(
    input wire logic core_clk,
    input wire logic [NUM_SOURCES-1:0] raise,
    input wire logic [NUM_SOURCES-1:0] serviced,
    input wire logic chain_fast,
    input wire logic chain_normal,
    output logic [NUM_SOURCES-1:0] source_req,
    output logic chained_fast_req_in_n,
    output logic chained_normal_req_in_n,
    output logic [ADDR_W-1:0] chained_vector_in
);
    ////////////////////////////////////////
    // levels held until serviced, a raise in the same call wins; moved off the edge to stay unaligned
    initial source_req = '0;
    always @(posedge core_clk) begin
        #1.3;
        source_req = (source_req & ~serviced) | raise;
    end
    // downstream controller; vector is junk while it does not request
    assign chained_fast_req_in_n = !chain_fast;
    assign chained_normal_req_in_n = !chain_normal;
    assign chained_vector_in = chain_normal ? CHAIN_VEC : ~CHAIN_VEC;
endmodule

// ### bench/ivc_properties.sv
`timescale 1ns/1ps
module ivc_properties
    import ivc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [NUM_SOURCES-1:0] source_req,
    input wire logic chained_normal_req_in_n,
    input wire logic chained_fast_req_in_n,
    input wire logic soft_set_write,
    input wire logic [NUM_SOURCES-1:0] soft_set_data,
    input wire logic soft_clear_write,
    input wire logic [NUM_SOURCES-1:0] soft_clear_data,
    input wire logic vector_read,
    input wire logic vector_write,
    input wire logic fast_int_out_n,
    input wire logic normal_int_out_n,
    input wire logic [NUM_SLOTS-1:0] slot_request_flag,
    input wire logic [NUM_LEVELS-1:0] in_service,
    input wire logic [NUM_SOURCES-1:0] source_enable_reg,
    input wire logic [NUM_SOURCES-1:0] fast_normal_select_reg,
    input wire logic [NUM_SOURCES-1:0] soft_request_reg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // enabled requests, hardware and forced alike
    logic [NUM_SOURCES-1:0] act;
    assign act = (source_req | soft_request_reg) & source_enable_reg;
    // outputs are combinational, so they match their cause in the same cycle
    a_fast_path: assert property (fast_int_out_n == !(|(act & fast_normal_select_reg) || !chained_fast_req_in_n))
        else $error("fast output wrong");
    a_normal_cause: assert property (!normal_int_out_n |-> |(act & ~fast_normal_select_reg) || !chained_normal_req_in_n)
        else $error("normal output without request");
    a_reset_clear: assert property (disable iff (1'b0) rst |=> soft_request_reg == '0 && in_service == '0)
        else $error("reset left state");
    a_soft_set: assert property (soft_set_write |=> (soft_request_reg & $past(soft_set_data)) == $past(soft_set_data))
        else $error("soft set lost");
    a_soft_clear: assert property (soft_clear_write && !soft_set_write |=> (soft_request_reg & $past(soft_clear_data)) == '0)
        else $error("soft clear lost");
    a_soft_hold: assert property (!soft_set_write && !soft_clear_write |=> $stable(soft_request_reg))
        else $error("soft request moved");
    a_read_mask: assert property (vector_read && !vector_write && slot_request_flag[0] |=> in_service[0] && normal_int_out_n)
        else $error("read did not mask");
    a_write_release: assert property (vector_write && !vector_read && $onehot(in_service) |=> in_service == '0)
        else $error("write did not release");
    a_slot_onehot: assert property ($onehot0(slot_request_flag))
        else $error("two slot flags");
endmodule

bind ivc_controller ivc_properties i_ivc_properties (.core_clk, .rst, .source_req, .chained_normal_req_in_n,
    .chained_fast_req_in_n, .soft_set_write, .soft_set_data, .soft_clear_write, .soft_clear_data, .vector_read,
    .vector_write, .fast_int_out_n, .normal_int_out_n, .slot_request_flag, .in_service, .source_enable_reg,
    .fast_normal_select_reg, .soft_request_reg);

// ### bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top
    import ivc_pkg::*;
;
    localparam logic [31:0] H0 = 32'h0000_4000, H1 = 32'h0000_4040, HD = 32'h0000_4800, HC = 32'h0000_5000;
    logic core_clk, chained_normal_req_in_n, chained_fast_req_in_n, fast_int_out_n, normal_int_out_n;
    logic rst = 1;
    logic chain_fast = 0;
    logic chain_normal = 0;
    logic [7:0] stb = '0;
    logic [31:0] wd = '0;
    logic [31:0] raise = '0;
    logic [31:0] serviced = '0;
    logic [3:0] slot_index = '0;
    ivc_slot_type slot_data = '0;
    logic [31:0] source_req, chained_vector_in, handler_vector_reg, source_enable_reg, fast_normal_select_reg;
    logic [31:0] soft_request_reg;
    ivc_status_type request_status;
    logic [15:0] slot_request_flag;
    logic [17:0] in_service;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    ////////////////////////////////////////
    // strobes: 0 soft set, 1 soft clear, 2 enable, 3 select, 4 slot, 5 default, 6 read, 7 write
    ivc_controller i_ivc_controller (.core_clk, .rst, .source_req, .chained_normal_req_in_n, .chained_fast_req_in_n,
        .chained_vector_in, .soft_set_write(stb[0]), .soft_set_data(wd), .soft_clear_write(stb[1]),
        .soft_clear_data(wd), .enable_write(stb[2]), .enable_data(wd), .select_write(stb[3]), .select_data(wd),
        .slot_write(stb[4]), .slot_index, .slot_data, .default_write(stb[5]), .default_data(wd),
        .vector_read(stb[6]), .vector_write(stb[7]), .fast_int_out_n, .normal_int_out_n, .handler_vector_reg,
        .request_status, .slot_request_flag, .in_service, .source_enable_reg, .fast_normal_select_reg,
        .soft_request_reg);
    ivc_periph_model #(.CHAIN_VEC(HC)) i_ivc_periph_model (.core_clk, .raise, .serviced, .chain_fast,
        .chain_normal, .source_req, .chained_fast_req_in_n, .chained_normal_req_in_n, .chained_vector_in);
    initial begin
        core_clk = 0;
        forever #2.5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////
    // one-cycle strobe, result looked at half a cycle after it lands
    task automatic cfg(input int k, input logic [31:0] d, input ivc_slot_type s = '0, input logic [3:0] i = '0);
        @(posedge core_clk);
        stb <= 8'h01 << k;
        wd <= d;
        slot_data <= s;
        slot_index <= i;
        @(posedge core_clk);
        stb <= '0;
        @(negedge core_clk);
    endtask
    // peripheral levels change, then wait out the two-stage sync
    task automatic per(input logic [31:0] r, input logic [31:0] s);
        @(posedge core_clk);
        raise <= r;
        serviced <= s;
        @(posedge core_clk);
        raise <= '0;
        serviced <= '0;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // watchdog: the sequence needs about 125 cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            end_sim();
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 0;
        @(negedge core_clk);
        `CHK("reset", 84'h3, {source_enable_reg, soft_request_reg, in_service, fast_int_out_n, normal_int_out_n})
        cfg(2, 32'h0000_121A);
        `CHK("enable", 32'h0000_121A, source_enable_reg)
        cfg(3, 32'h0000_1000);
        cfg(4, 0, '{1'b1, 5'h03, H0}, 0);
        cfg(4, 0, '{1'b1, 5'h04, H1}, 1); // timer line
        cfg(5, HD);
        per(32'h0000_1200, 0);
        `CHK("both out", 2'h0, {fast_int_out_n, normal_int_out_n})
        `CHK("fast st", 32'h0000_1000, request_status.fast)
        `CHK("norm st", 32'h0000_0200, request_status.normal)
        per(32'h0010_0000, 32'h0000_1200);
        `CHK("raw", 32'h0010_0000, request_status.raw)
        `CHK("disabled", 2'h3, {fast_int_out_n, normal_int_out_n})
        per(32'h0000_0018, '1);
        `CHK("flag0", 16'h0001, slot_request_flag)
        cfg(6, 0);
        `CHK("vec0", H0, handler_vector_reg)
        `CHK("mask0", 19'h0_0003, {in_service, normal_int_out_n})
        cfg(7, 0);
        `CHK("release", 19'h0, {in_service, normal_int_out_n})
        per(0, 32'h0000_0008);
        `CHK("flag1", 16'h0002, slot_request_flag)
        cfg(6, 0);
        `CHK("vec1", H1, handler_vector_reg)
        cfg(7, 0);
        // request drops before the read: stored vector returned, no mask set
        per(32'h0000_0008, '1);
        per(0, '1);
        cfg(6, 0);
        `CHK("transient", {H0, 18'h0_0000, 1'b1}, {handler_vector_reg, in_service, normal_int_out_n})
        per(32'h0000_0200, '1);
        cfg(6, 0);
        `CHK("nonvect", {HD, 18'h1_0000}, {handler_vector_reg, in_service})
        cfg(7, 0);
        per(0, '1);
        cfg(0, 32'h0000_0002); // software line
        `CHK("soft", 33'h0_0000_0004, {soft_request_reg, normal_int_out_n})
        cfg(1, 32'h0000_0002);
        `CHK("soft clr", 33'h0_0000_0001, {soft_request_reg, normal_int_out_n})
        @(posedge core_clk);
        chain_normal <= 1;
        per(0, 0);
        cfg(6, 0);
        `CHK("chained", {HC, 18'h2_0000, 1'b1}, {handler_vector_reg, in_service, normal_int_out_n})
        cfg(7, 0);
        @(posedge core_clk);
        chain_normal <= 0;
        chain_fast <= 1;
        per(0, 0);
        `CHK("chain fast", 2'h1, {fast_int_out_n, normal_int_out_n})
        @(posedge core_clk);
        chain_fast <= 0;
        cfg(3, 32'h0000_1008);
        per(32'h0000_0008, 0);
        `CHK("fast slot", 18'h1_0000, {fast_int_out_n, normal_int_out_n, slot_request_flag})
        per(0, '1);
        // output must assert before any edge sees the request: wake-up path
        @(posedge core_clk);
        raise <= 32'h0000_0200;
        @(negedge core_clk);
        `CHK("async out", 1'b0, normal_int_out_n)
        per(0, '1);
        end_sim();
    end
endmodule

// ### design/ivc_controller.sv
`timescale 1ns/1ps
module ivc_controller
    import ivc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [NUM_SOURCES-1:0] source_req,
    input wire logic chained_normal_req_in_n,
    input wire logic chained_fast_req_in_n,
    input wire logic [ADDR_W-1:0] chained_vector_in,
    input wire logic soft_set_write,
    input wire logic [NUM_SOURCES-1:0] soft_set_data,
    input wire logic soft_clear_write,
    input wire logic [NUM_SOURCES-1:0] soft_clear_data,
    input wire logic enable_write,
    input wire logic [NUM_SOURCES-1:0] enable_data,
    input wire logic select_write,
    input wire logic [NUM_SOURCES-1:0] select_data,
    input wire logic slot_write,
    input wire logic [SLOT_IDX_W-1:0] slot_index,
    input wire ivc_slot_type slot_data,
    input wire logic default_write,
    input wire logic [ADDR_W-1:0] default_data,
    input wire logic vector_read,
    input wire logic vector_write,
    output logic fast_int_out_n,
    output logic normal_int_out_n,
    output logic [ADDR_W-1:0] handler_vector_reg,
    output ivc_status_type request_status,
    output logic [NUM_SLOTS-1:0] slot_request_flag,
    output logic [NUM_LEVELS-1:0] in_service,
    output logic [NUM_SOURCES-1:0] source_enable_reg,
    output logic [NUM_SOURCES-1:0] fast_normal_select_reg,
    output logic [NUM_SOURCES-1:0] soft_request_reg
);

    ////////////////////////////////////////////////////////////////////////
    // arbitration helper
    // first requesting level not masked by an in-service level at or above it
    function automatic logic [NUM_LEVELS-1:0] grant(
        input logic [NUM_LEVELS-1:0] req,
        input logic [NUM_LEVELS-1:0] busy
    );
        logic blocked;
        logic found;
        logic [NUM_LEVELS-1:0] win;
        blocked = 1'b0;
        found = 1'b0;
        win = LVL_RESET;
        for (int i = 0; i < NUM_LEVELS; i++) begin
            blocked = blocked | busy[i];
            if (req[i] && !blocked && !found) begin // see [RL10] [RL18]
                win[i] = 1'b1;
                found = 1'b1;
            end
        end
        return win;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // configuration state
    ivc_slot_type slot_cfg [NUM_SLOTS];
    ivc_slot_type next_slot_cfg [NUM_SLOTS];
    logic [ADDR_W-1:0] default_handler;
    logic [ADDR_W-1:0] next_default_handler;
    logic [NUM_SOURCES-1:0] next_source_enable;
    logic [NUM_SOURCES-1:0] next_select;
    logic [NUM_SOURCES-1:0] next_soft;

    // software writes; a set in the same cycle as a clear wins
    always_comb begin
        next_source_enable = enable_write ? enable_data : source_enable_reg; // see [RL25]
        next_select = select_write ? select_data : fast_normal_select_reg;
        next_soft = soft_request_reg;
        if (soft_clear_write) begin
            next_soft = next_soft & ~soft_clear_data; // see [RL22]
        end
        if (soft_set_write) begin
            next_soft = next_soft | soft_set_data; // see [RL6]
        end
        next_default_handler = default_write ? default_data : default_handler;
        for (int s = 0; s < NUM_SLOTS; s++) begin
            next_slot_cfg[s] = slot_cfg[s];
            if (slot_write && slot_index == s[SLOT_IDX_W-1:0]) begin
                next_slot_cfg[s] = slot_data;
            end
        end
    end

    // reset drops every software-set bit, so only chained requests survive it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            source_enable_reg <= SRC_RESET; // see [RL24]
            fast_normal_select_reg <= SRC_RESET;
            soft_request_reg <= SRC_RESET;
            default_handler <= ADDR_RESET;
            for (int s = 0; s < NUM_SLOTS; s++) begin
                slot_cfg[s] <= SLOT_CFG_RESET;
            end
        end else begin
            source_enable_reg <= next_source_enable;
            fast_normal_select_reg <= next_select;
            soft_request_reg <= next_soft;
            default_handler <= next_default_handler;
            for (int s = 0; s < NUM_SLOTS; s++) begin
                slot_cfg[s] <= next_slot_cfg[s];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request synchroniser for the clocked side only
    // the output path uses the raw lines so it works with the clock stopped
    logic [NUM_SOURCES-1:0] req_meta;
    logic [NUM_SOURCES-1:0] req_sync;
    logic chained_meta;
    logic chained_sync;
    logic [NUM_SOURCES-1:0] next_req_meta;
    logic [NUM_SOURCES-1:0] next_req_sync;
    logic next_chained_meta;
    logic next_chained_sync;

    // first stage samples the pins; only the second stage reads the first
    always_comb begin
        next_req_meta = source_req; // see [RL4]
        next_req_sync = req_meta;
        next_chained_meta = ~chained_normal_req_in_n; // see [RL23]
        next_chained_sync = chained_meta;
    end

    // two flops per line; costs two cycles of status latency
    always_ff @(posedge core_clk) begin
        if (rst) begin
            req_meta <= SRC_RESET;
            req_sync <= SRC_RESET;
            chained_meta <= 1'b0;
            chained_sync <= 1'b0;
        end else begin
            req_meta <= next_req_meta;
            req_sync <= next_req_sync;
            chained_meta <= next_chained_meta;
            chained_sync <= next_chained_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request logic, built twice: raw for the outputs, synced for state
    logic [NUM_SOURCES-1:0] raw_any;
    logic [NUM_SOURCES-1:0] raw_fast;
    logic [NUM_SOURCES-1:0] raw_normal;
    logic [NUM_SOURCES-1:0] syn_any;
    logic [NUM_SOURCES-1:0] syn_fast;
    logic [NUM_SOURCES-1:0] syn_normal;

    // forced requests join before the enable mask
    assign raw_any = source_req | soft_request_reg; // see [RL6] [RL3]
    assign raw_fast = raw_any & source_enable_reg & fast_normal_select_reg; // see [RL7]
    assign raw_normal = raw_any & source_enable_reg & ~fast_normal_select_reg; // see [RL7]
    assign syn_any = req_sync | soft_request_reg;
    assign syn_fast = syn_any & source_enable_reg & fast_normal_select_reg;
    assign syn_normal = syn_any & source_enable_reg & ~fast_normal_select_reg;

    // vectored slots and the sources they claim
    logic [NUM_SLOTS-1:0] raw_slot_req;
    logic [NUM_SLOTS-1:0] syn_slot_req;
    logic [NUM_SOURCES-1:0] claim [NUM_SLOTS];
    logic [NUM_SOURCES-1:0] claimed;

    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++) begin : gen_slot
            // slot only sees normal-selected sources, so never reaches fast
            assign raw_slot_req[g] = slot_cfg[g].enable
                & raw_normal[slot_cfg[g].source]; // see [RL21] [RL2]
            assign syn_slot_req[g] = slot_cfg[g].enable
                & syn_normal[slot_cfg[g].source];
            assign claim[g] = slot_cfg[g].enable
                ? (SRC_RESET | (NUM_SOURCES'(1) << slot_cfg[g].source)) : SRC_RESET;
        end
    endgenerate

    // sources already owned by an enabled slot
    always_comb begin
        claimed = SRC_RESET;
        for (int s = 0; s < NUM_SLOTS; s++) begin
            claimed = claimed | claim[s];
        end
    end

    // unclaimed normal requests merge into one non-vectored request
    logic raw_nonvect;
    logic syn_nonvect;
    assign raw_nonvect = |(raw_normal & ~claimed); // see [RL15]
    assign syn_nonvect = |(syn_normal & ~claimed);

    logic [NUM_LEVELS-1:0] raw_levels;
    logic [NUM_LEVELS-1:0] syn_levels;
    logic [NUM_LEVELS-1:0] raw_win;
    logic [NUM_LEVELS-1:0] syn_win;
    assign raw_levels = {~chained_normal_req_in_n, raw_nonvect, raw_slot_req}; // see [RL19]
    assign syn_levels = {chained_sync, syn_nonvect, syn_slot_req};
    assign raw_win = grant(raw_levels, in_service);
    assign syn_win = grant(syn_levels, in_service);

    ////////////////////////////////////////////////////////////////////////
    // interrupt outputs, deliberately unregistered so a stopped clock
    // still lets an interrupt wake the system
    assign fast_int_out_n = ~(|raw_fast | ~chained_fast_req_in_n); // see [RL14] [RL12] [RL23]
    assign normal_int_out_n = ~(|raw_win); // see [RL18] [RL12] [RL11] [RL23]

    ////////////////////////////////////////////////////////////////////////
    // vector address selection and priority masking
    logic [ADDR_W-1:0] win_addr;
    logic [ADDR_W-1:0] stored_vector;
    logic [ADDR_W-1:0] next_stored_vector;
    logic [ADDR_W-1:0] next_handler_vector;
    logic [NUM_LEVELS-1:0] next_in_service;
    logic [NUM_LEVELS-1:0] lowest_busy;
    logic top_found;

    // winner's handler address
    always_comb begin
        win_addr = ADDR_RESET;
        for (int s = 0; s < NUM_SLOTS; s++) begin
            if (syn_win[s]) begin
                win_addr = slot_cfg[s].handler; // see [RL17]
            end
        end
        if (syn_win[LVL_NONVECT]) begin
            win_addr = default_handler;
        end
        if (syn_win[LVL_CHAINED]) begin
            win_addr = chained_vector_in;
        end
    end

    // highest-priority in-service level, released by a vector write
    always_comb begin
        lowest_busy = LVL_RESET;
        top_found = 1'b0;
        for (int i = 0; i < NUM_LEVELS; i++) begin
            if (in_service[i] && !top_found) begin
                lowest_busy[i] = 1'b1;
                top_found = 1'b1;
            end
        end
    end

    // read sets and write clears the masking; the write applies first
    always_comb begin
        next_stored_vector = stored_vector;
        next_handler_vector = handler_vector_reg;
        next_in_service = in_service;
        // the vector stays stored after a transient request drops
        if (|syn_win) begin
            next_stored_vector = win_addr;
        end
        if (vector_write) begin
            next_in_service = next_in_service & ~lowest_busy; // see [RL9]
        end
        if (vector_read) begin
            next_handler_vector = (|syn_win) ? win_addr : stored_vector; // see [RL8] [RL5]
            // a dropped request sets no mask; lower levels stay live
            next_in_service = next_in_service | syn_win; // see [RL8] [RL5]
        end
    end

    // masking state; a stopped clock freezes it but not the outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stored_vector <= ADDR_RESET;
            handler_vector_reg <= ADDR_RESET;
            in_service <= LVL_RESET; // see [RL24]
        end else begin
            stored_vector <= next_stored_vector;
            handler_vector_reg <= next_handler_vector;
            in_service <= next_in_service;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status and slot flags, registered from the synced view
    ivc_status_type next_status;
    logic [NUM_SLOTS-1:0] next_slot_flag;

    always_comb begin
        next_status.raw = syn_any; // see [RL1]
        next_status.fast = syn_fast; // see [RL7]
        next_status.normal = syn_normal;
        next_slot_flag = syn_win[NUM_SLOTS-1:0]; // see [RL16]
    end

    // status lags the pins by the sync stages plus this register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            request_status <= '{SRC_RESET, SRC_RESET, SRC_RESET};
            slot_request_flag <= SLOT_RESET;
        end else begin
            request_status <= next_status;
            slot_request_flag <= next_slot_flag;
        end
    end

endmodule

// ### design/ivc_pkg.sv
// Functional notes
// [RL1] thirty-two request inputs, one bit position each in every per-source word
// [RL2] sixteen vectored slots; a slot source only ever raises the normal output
// [RL3] peripherals hold active-high level requests until serviced; no pulses
// [RL4] request inputs may change asynchronously to the clock
// [RL5] dropped request still returns stored vector on read, but sets no masking
// [RL6] software-forced requests are ORed with hardware requests before enabling
// [RL7] disabled requests suppressed; enabled ones steered to fast or normal status
// [RL8] vector read returns winner address and masks it and all lower levels
// [RL9] any vector write releases the current in-service level
// [RL10] rank: fast, then slot 0 to slot 15, then non-vectored normal
// [RL11] fast and normal outputs may be asserted together
// [RL12] request-to-output paths are combinational, working with the clock stopped
// [RL13] power control restarts clocks when an interrupt output asserts
// [RL14] fast output is local enabled fast requests ORed with chained fast input
// [RL15] enabled normal requests not claimed by a slot form one non-vectored request
// [RL16] slot flag set only when its source is active and it is top requester
// [RL17] each slot supplies a 32-bit handler address for the returned vector
// [RL18] arbitration over slots, non-vectored and chained; output only if not in service
// [RL19] chained normal request input acts as the external arbitration request
// [RL20] integrators wire bit 1 software, 2-3 debug, 4-5 timers by convention
// [RL21] vectored request needs source enabled, normal selected, slot enabled
// [RL22] forced requests clear only by writing ones to the clear register
// [RL23] n-suffixed outputs and chained inputs are active low
// [RL24] reset clears enables, selections, forced requests and masking
// [RL25] processor performs single reads and writes of the register ports
package ivc_pkg;
    localparam int NUM_SOURCES = 32;
    localparam int NUM_SLOTS = 16;
    localparam int SRC_IDX_W = 5;
    localparam int SLOT_IDX_W = 4;
    localparam int ADDR_W = 32;
    // arbitration levels: slots first, then non-vectored, then chained
    localparam int LVL_NONVECT = 16;
    localparam int LVL_CHAINED = 17;
    localparam int NUM_LEVELS = 18;

    localparam logic [NUM_SOURCES-1:0] SRC_RESET = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [NUM_LEVELS-1:0] LVL_RESET = 18'h0_0000;
    localparam logic [NUM_SLOTS-1:0] SLOT_RESET = 16'h0000;

    // one vectored slot: enable, claimed source, handler address
    typedef struct packed {
        logic enable;
        logic [SRC_IDX_W-1:0] source;
        logic [ADDR_W-1:0] handler;
    } ivc_slot_type;

    localparam ivc_slot_type SLOT_CFG_RESET = '{1'b0, 5'h00, 32'h0000_0000};

    // per-source request words handed to the status outputs
    typedef struct packed {
        logic [NUM_SOURCES-1:0] raw;
        logic [NUM_SOURCES-1:0] fast;
        logic [NUM_SOURCES-1:0] normal;
    } ivc_status_type;
endpackage
